// ==== logic/tct_pkg.sv ====
// Overview of operation
// - Count wraps FFFFh to 0000h, setting flag
// - Interrupt needs on, enable, peripheral, global
// - Flag stays set until software clears it
// - Software clears count and flag first
// - Sleep counting only as asynchronous counter
// - Software arms on, enables, sync-disable for wake
// - Overflow wakes from sleep, next instruction
// - Wake with global enable vectors to 0004h
// - Capture copies count into capture/compare pair
// - Compare match of count triggers event
// - Special event trigger clears the count
// - Special event clear never sets overflow flag
// - Count write beats coincident special event
// - Software uses synchronous mode for special event
package tct_pkg;

   localparam int CNT_W = 16;
   localparam int BYTE_W = 8;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 3;

   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] ISR_VECTOR = 16'h0004;

   // Register offsets of the controller's own map
   localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] REG_COUNT_LO = 3'h1;
   localparam logic [ADDR_W-1:0] REG_COUNT_HI = 3'h2;
   localparam logic [ADDR_W-1:0] REG_FLAG = 3'h3;
   localparam logic [ADDR_W-1:0] REG_CAPCOMP_LO = 3'h4;
   localparam logic [ADDR_W-1:0] REG_CAPCOMP_HI = 3'h5;

   // Control register fields
   localparam int CTRL_W = 9;
   localparam int CTRL_ON = 0;
   localparam int CTRL_OVF_IE = 1;
   localparam int CTRL_PERIPH_IE = 2;
   localparam int CTRL_GLOBAL_IE = 3;
   localparam int CTRL_SYNC_DIS = 4;
   localparam int CTRL_CLK_SRC = 5;
   localparam int CTRL_SLEEP = 6;
   localparam int CTRL_MODE_LO = 7;
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

   // Flag register fields
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMP = 1;
   localparam int FLAG_IRQ = 2;

   typedef enum logic [1:0] {
      TCT_CCP_OFF,
      TCT_CCP_CAPTURE,
      TCT_CCP_COMPARE,
      TCT_CCP_SPECIAL
   } tct_ccp_mode_t;

   // Replace one byte of a 16-bit pair
   function automatic logic [CNT_W-1:0] tct_put_byte(
      input logic [CNT_W-1:0] value,
      input logic [BYTE_W-1:0] data,
      input logic high);
      logic [CNT_W-1:0] r;
      r = value;
      if (high) begin
         r[CNT_W-1:BYTE_W] = data;
      end else begin
         r[BYTE_W-1:0] = data;
      end
      return r;
   endfunction : tct_put_byte

endpackage : tct_pkg

// ==== logic/tct_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tct_link_if;
   import tct_pkg::*;

   logic timer_on_bit;
   logic overflow_irq_enable;
   logic peripheral_irq_enable;
   logic global_irq_enable;
   logic sync_disable_bit;
   logic clock_source_select;
   logic sleep;
   tct_ccp_mode_t ccp_mode;
   logic [BYTE_W-1:0] byte_wdata;
   logic count_wr_lo;
   logic count_wr_hi;
   logic capcomp_wr_lo;
   logic capcomp_wr_hi;
   logic flag_clear;
   logic capture_event;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] capcomp;
   logic overflow_irq_flag;
   logic irq;
   logic wake;
   logic compare_event;

   modport dev (
      input timer_on_bit, overflow_irq_enable, peripheral_irq_enable,
      input global_irq_enable, sync_disable_bit, clock_source_select,
      input sleep, ccp_mode, byte_wdata, count_wr_lo, count_wr_hi,
      input capcomp_wr_lo, capcomp_wr_hi, flag_clear, capture_event,
      output count, capcomp, overflow_irq_flag, irq, wake, compare_event
   );

   modport ctl (
      output timer_on_bit, overflow_irq_enable, peripheral_irq_enable,
      output global_irq_enable, sync_disable_bit, clock_source_select,
      output sleep, ccp_mode, byte_wdata, count_wr_lo, count_wr_hi,
      output capcomp_wr_lo, capcomp_wr_hi, flag_clear, capture_event,
      input count, capcomp, overflow_irq_flag, irq, wake, compare_event
   );

endinterface : tct_link_if
`default_nettype wire

// ==== logic/tct_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tct_timer (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic EXT_CLK,
   output logic IRQ,
   output logic VECTOR_TAKE,
   output logic [tct_pkg::CNT_W-1:0] VECTOR_ADDR,
   tct_link_if.dev LINK
);
   import tct_pkg::*;

   typedef struct packed {
      logic ext_s1;
      logic ext_s2;
      logic ext_prev;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] capcomp;
      logic flag;
      logic match_prev;
      logic irq;
      logic wake;
      logic vec_take;
      logic cmp_event;
   } tct_dev_state_t;

   tct_dev_state_t s;
   tct_dev_state_t next_s;

   logic tick;
   logic run_ok;
   logic inc;
   logic wrap;
   logic cnt_write;
   logic cc_write;
   logic compare_on;
   logic match;
   logic cmp_hit;
   logic special;
   logic ovf_set;

   always_comb begin
      next_s = s;

      // Pin edge is taken only from the second synchroniser stage
      next_s.ext_s1 = EXT_CLK;
      next_s.ext_s2 = s.ext_s1;
      next_s.ext_prev = s.ext_s2;

      // Internal source counts every instruction cycle
      if (LINK.clock_source_select) begin
         tick = s.ext_s2 & ~s.ext_prev;
      end else begin
         tick = 1'b1;
      end

      // Asleep, only the unsynchronised external counter runs
      run_ok = ~LINK.sleep
         | (LINK.sync_disable_bit & LINK.clock_source_select);

      inc = LINK.timer_on_bit & tick & run_ok;
      wrap = inc & (s.count == CNT_MAX);

      cnt_write = LINK.count_wr_lo | LINK.count_wr_hi;
      cc_write = LINK.capcomp_wr_lo | LINK.capcomp_wr_hi;

      compare_on = (LINK.ccp_mode == TCT_CCP_COMPARE)
         | (LINK.ccp_mode == TCT_CCP_SPECIAL);
      match = compare_on & (s.count == s.capcomp);
      // One event per arrival at the match value, not per cycle held
      cmp_hit = match & ~s.match_prev;
      special = cmp_hit & (LINK.ccp_mode == TCT_CCP_SPECIAL);
      next_s.match_prev = match;
      next_s.cmp_event = cmp_hit;

      // Priority: software write, then special clear, then increment
      if (cnt_write) begin
         if (LINK.count_wr_lo) begin
            next_s.count = tct_put_byte(next_s.count,
               LINK.byte_wdata, 1'b0);
         end
         if (LINK.count_wr_hi) begin
            next_s.count = tct_put_byte(next_s.count,
               LINK.byte_wdata, 1'b1);
         end
      end else if (special) begin
         next_s.count = CNT_ZERO;
      end else if (inc) begin
         next_s.count = s.count + 16'h0001;
      end

      // A wrap lost to a write or a special clear raises nothing
      ovf_set = wrap & ~cnt_write & ~special;

      // Set wins over a coincident clear
      next_s.flag = ovf_set | (s.flag & ~LINK.flag_clear);

      if (cc_write) begin
         if (LINK.capcomp_wr_lo) begin
            next_s.capcomp = tct_put_byte(next_s.capcomp,
               LINK.byte_wdata, 1'b0);
         end
         if (LINK.capcomp_wr_hi) begin
            next_s.capcomp = tct_put_byte(next_s.capcomp,
               LINK.byte_wdata, 1'b1);
         end
      end else if ((LINK.ccp_mode == TCT_CCP_CAPTURE)
                   & LINK.capture_event) begin
         next_s.capcomp = s.count;
      end

      next_s.irq = s.flag & LINK.timer_on_bit
         & LINK.overflow_irq_enable & LINK.peripheral_irq_enable
         & LINK.global_irq_enable;

      // Wake needs no global enable; the core resumes in line
      next_s.wake = ovf_set & LINK.sleep & LINK.timer_on_bit
         & LINK.overflow_irq_enable & LINK.peripheral_irq_enable;
      next_s.vec_take = next_s.wake & LINK.global_irq_enable;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign IRQ = s.irq;
   assign VECTOR_TAKE = s.vec_take;
   assign VECTOR_ADDR = ISR_VECTOR;
   assign LINK.count = s.count;
   assign LINK.capcomp = s.capcomp;
   assign LINK.overflow_irq_flag = s.flag;
   assign LINK.irq = s.irq;
   assign LINK.wake = s.wake;
   assign LINK.compare_event = s.cmp_event;

endmodule : tct_timer
`default_nettype wire

// ==== logic/tct_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tct_ctrl (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [tct_pkg::ADDR_W-1:0] ADDR,
   input wire logic [tct_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [tct_pkg::DATA_W-1:0] RDATA,
   input wire logic CAPTURE_PIN,
   output logic COMPARE_IRQ,
   tct_link_if.ctl LINK
);
   import tct_pkg::*;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [BYTE_W-1:0] byte_wdata;
      logic count_wr_lo;
      logic count_wr_hi;
      logic capcomp_wr_lo;
      logic capcomp_wr_hi;
      logic flag_clear;
      logic cap_s1;
      logic cap_s2;
      logic cap_prev;
      logic cap_event;
      logic cmp_flag;
      logic [DATA_W-1:0] rdata;
   } tct_ctl_state_t;

   tct_ctl_state_t s;
   tct_ctl_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.byte_wdata = WDATA[BYTE_W-1:0];
      next_s.count_wr_lo = WR & (ADDR == REG_COUNT_LO);
      next_s.count_wr_hi = WR & (ADDR == REG_COUNT_HI);
      next_s.capcomp_wr_lo = WR & (ADDR == REG_CAPCOMP_LO);
      next_s.capcomp_wr_hi = WR & (ADDR == REG_CAPCOMP_HI);
      next_s.flag_clear = WR & (ADDR == REG_FLAG) & WDATA[FLAG_OVF];

      // Leaving sleep drops the sleep bit; a same-cycle write wins
      if (LINK.wake) begin
         next_s.ctrl[CTRL_SLEEP] = 1'b0;
      end
      if (WR & (ADDR == REG_CTRL)) begin
         next_s.ctrl = WDATA[CTRL_W-1:0];
      end

      next_s.cap_s1 = CAPTURE_PIN;
      next_s.cap_s2 = s.cap_s1;
      next_s.cap_prev = s.cap_s2;
      next_s.cap_event = s.cap_s2 & ~s.cap_prev;

      next_s.cmp_flag = LINK.compare_event | (s.cmp_flag
         & ~(WR & (ADDR == REG_FLAG) & WDATA[FLAG_CMP]));

      next_s.rdata = '0;
      if (RD) begin
         unique case (ADDR)
            REG_CTRL: next_s.rdata = {7'h00, s.ctrl};
            REG_COUNT_LO: next_s.rdata = {8'h00, LINK.count[7:0]};
            REG_COUNT_HI: next_s.rdata = {8'h00, LINK.count[15:8]};
            REG_FLAG: next_s.rdata = {13'h0000, LINK.irq, s.cmp_flag,
               LINK.overflow_irq_flag};
            REG_CAPCOMP_LO: next_s.rdata = {8'h00, LINK.capcomp[7:0]};
            REG_CAPCOMP_HI: next_s.rdata = {8'h00, LINK.capcomp[15:8]};
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign RDATA = s.rdata;
   assign COMPARE_IRQ = s.cmp_flag;
   assign LINK.timer_on_bit = s.ctrl[CTRL_ON];
   assign LINK.overflow_irq_enable = s.ctrl[CTRL_OVF_IE];
   assign LINK.peripheral_irq_enable = s.ctrl[CTRL_PERIPH_IE];
   assign LINK.global_irq_enable = s.ctrl[CTRL_GLOBAL_IE];
   // Asynchronous mode may miss special events; software's choice
   assign LINK.sync_disable_bit = s.ctrl[CTRL_SYNC_DIS];
   assign LINK.clock_source_select = s.ctrl[CTRL_CLK_SRC];
   assign LINK.sleep = s.ctrl[CTRL_SLEEP];
   assign LINK.ccp_mode = tct_ccp_mode_t'(s.ctrl[CTRL_MODE_LO +: 2]);
   assign LINK.byte_wdata = s.byte_wdata;
   assign LINK.count_wr_lo = s.count_wr_lo;
   assign LINK.count_wr_hi = s.count_wr_hi;
   assign LINK.capcomp_wr_lo = s.capcomp_wr_lo;
   assign LINK.capcomp_wr_hi = s.capcomp_wr_hi;
   assign LINK.flag_clear = s.flag_clear;
   assign LINK.capture_event = s.cap_event;

endmodule : tct_ctrl
`default_nettype wire

// ==== testbench/tct_link_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tct_link_monitor (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic timer_on_bit,
   input wire logic overflow_irq_enable,
   input wire logic peripheral_irq_enable,
   input wire logic global_irq_enable,
   input wire logic sync_disable_bit,
   input wire logic clock_source_select,
   input wire logic sleep,
   input wire logic [1:0] ccp_mode,
   input wire logic [tct_pkg::BYTE_W-1:0] byte_wdata,
   input wire logic count_wr_lo,
   input wire logic count_wr_hi,
   input wire logic capcomp_wr_lo,
   input wire logic capcomp_wr_hi,
   input wire logic flag_clear,
   input wire logic capture_event,
   input wire logic [tct_pkg::CNT_W-1:0] count,
   input wire logic [tct_pkg::CNT_W-1:0] capcomp,
   input wire logic overflow_irq_flag,
   input wire logic irq,
   input wire logic wake,
   input wire logic compare_event
);
   import tct_pkg::*;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic en;
   logic cw;
   logic sp;
   assign en = timer_on_bit & overflow_irq_enable & peripheral_irq_enable;
   assign cw = count_wr_lo | count_wr_hi;
   assign sp = ccp_mode == TCT_CCP_SPECIAL;
   // Match counts only on arrival, a held match is no new event
   sequence arrive;
      ccp_mode inside {TCT_CCP_COMPARE, TCT_CCP_SPECIAL}
         && count == capcomp && !$past(count == capcomp);
   endsequence
   chk_wrap_flag: assert property (
      $past(count) == CNT_MAX && count == CNT_ZERO && !$past(cw) && !$past(sp)
      |-> overflow_irq_flag) else $error("wrap without flag");
   chk_irq_gate: assert property (
      irq == $past(overflow_irq_flag && en && global_irq_enable))
      else $error("irq gating wrong");
   chk_flag_sticky: assert property (
      $fell(overflow_irq_flag) |-> $past(flag_clear))
      else $error("flag dropped by itself");
   chk_off_hold: assert property (
      !timer_on_bit && !cw && !sp |=> $stable(count)
      && !$rose(overflow_irq_flag)) else $error("stopped timer moved");
   chk_sleep_hold: assert property (
      sleep && !(sync_disable_bit && clock_source_select) && !cw && !sp
      |=> $stable(count)) else $error("counted in sleep");
   chk_wake_pulse: assert property (
      $rose(overflow_irq_flag) && $past(sleep && en) |-> wake)
      else $error("no wake on overflow");
   chk_wake_sleep: assert property (
      wake |=> !sleep) else $error("sleep kept after wake");
   chk_capture_copy: assert property (
      capture_event && ccp_mode == TCT_CCP_CAPTURE
      && !capcomp_wr_lo && !capcomp_wr_hi
      |=> capcomp == $past(count)) else $error("capture value wrong");
   chk_compare_hit: assert property (
      arrive |=> compare_event) else $error("match missed");
   chk_special_clear: assert property (
      compare_event && $past(sp) && !$past(cw)
      |-> count == CNT_ZERO && !$rose(overflow_irq_flag))
      else $error("special clear wrong");
   chk_write_wins: assert property (
      count_wr_lo |=> count[BYTE_W-1:0] == $past(byte_wdata))
      else $error("count write lost");
endmodule : tct_link_monitor
`default_nettype wire

// ==== testbench/tb_timer_overflow_and_ccp_timebase.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_timer_overflow_and_ccp_timebase;
   import tct_pkg::*;
   logic CLK_SYS = 1'h0;
   logic RST = 1'h1;
   logic EXT_CLK = 1'h0;
   logic CAPTURE_PIN = 1'h0;
   logic WR = 1'h0;
   logic RD = 1'h0;
   logic [ADDR_W-1:0] ADDR = 3'h0;
   logic [DATA_W-1:0] WDATA = 16'h0000;
   logic [DATA_W-1:0] RDATA;
   logic [CNT_W-1:0] VECTOR_ADDR;
   logic IRQ;
   logic VECTOR_TAKE;
   logic COMPARE_IRQ;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   int vt_n = 0;
   tct_link_if link();
   tct_timer tct_timer_i(.CLK_SYS(CLK_SYS), .RST(RST), .EXT_CLK(EXT_CLK),
      .IRQ(IRQ), .VECTOR_TAKE(VECTOR_TAKE), .VECTOR_ADDR(VECTOR_ADDR),
      .LINK(link.dev));
   tct_ctrl tct_ctrl_i(.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .CAPTURE_PIN(CAPTURE_PIN), .COMPARE_IRQ(COMPARE_IRQ), .LINK(link.ctl));
   tct_link_monitor tct_link_monitor_i(.CLK_SYS(CLK_SYS), .RST(RST),
      .timer_on_bit(link.timer_on_bit), .sleep(link.sleep),
      .overflow_irq_enable(link.overflow_irq_enable),
      .peripheral_irq_enable(link.peripheral_irq_enable),
      .global_irq_enable(link.global_irq_enable),
      .sync_disable_bit(link.sync_disable_bit),
      .clock_source_select(link.clock_source_select),
      .ccp_mode(link.ccp_mode), .byte_wdata(link.byte_wdata),
      .count_wr_lo(link.count_wr_lo), .count_wr_hi(link.count_wr_hi),
      .capcomp_wr_lo(link.capcomp_wr_lo),
      .capcomp_wr_hi(link.capcomp_wr_hi),
      .flag_clear(link.flag_clear), .capture_event(link.capture_event),
      .count(link.count), .capcomp(link.capcomp), .irq(link.irq),
      .overflow_irq_flag(link.overflow_irq_flag), .wake(link.wake),
      .compare_event(link.compare_event));
   always #5 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) begin
      cyc++;
      if (VECTOR_TAKE === 1'h1) vt_n++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge CLK_SYS);
      WR <= 1'h1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK_SYS);
      WR <= 1'h0;
   endtask : wr
   task automatic rdc(input string n, input logic [ADDR_W-1:0] a,
      input logic [15:0] e);
      @(posedge CLK_SYS);
      RD <= 1'h1;
      ADDR <= a;
      @(posedge CLK_SYS);
      RD <= 1'h0;
      #1 chk(n, e, RDATA);
   endtask : rdc
   // Stop first so the clears cannot race a running count
   task automatic prep(input logic [15:0] n);
      wr(REG_CTRL, 16'h0000);
      wr(REG_FLAG, 16'h0003);
      wr(REG_COUNT_LO, {8'h00, n[7:0]});
      wr(REG_COUNT_HI, {8'h00, n[15:8]});
   endtask : prep
   function automatic logic [15:0] flag_exp(input logic [3:0] c);
      return {13'h0000, &c, 1'h0, c[0]};
   endfunction : flag_exp
   initial begin
      logic [15:0] v;
      logic [3:0] c;
      void'($urandom(32'h6acd));
      repeat (20) @(posedge CLK_SYS);
      RST <= 1'h0;
      rdc("ctrl", REG_CTRL, 16'h0000);
      wr(3'h7, 16'hffff);
      rdc("unmapped", 3'h6, 16'h0000);
      chk("vector", 16'h0004, VECTOR_ADDR);
      for (int i = 0; i < 10; i++) begin
         c = (i < 2) ? 4'hf - 4'(i) : 4'($urandom);
         prep(16'hffff);
         wr(REG_CTRL, {12'h000, c});
         repeat (4) @(posedge CLK_SYS);
         rdc("flag", REG_FLAG, flag_exp(c));
         chk("irq", {15'h0000, &c}, {15'h0000, IRQ});
         rdc("cnt_hi", REG_COUNT_HI, c[0] ? 16'h0000 : 16'h00ff);
      end
      // First pass wakes without the global enable, so no vector
      for (int g = 0; g < 2; g++) begin
         prep(16'hffff);
         wr(REG_CTRL, 16'h004f);
         repeat (6) @(posedge CLK_SYS);
         rdc("sleep_hold", REG_COUNT_HI, 16'h00ff);
         wr(REG_CTRL, (g == 1) ? 16'h007f : 16'h0077);
         @(posedge CLK_SYS);
         EXT_CLK <= 1'h1;
         repeat (8) @(posedge CLK_SYS);
         EXT_CLK <= 1'h0;
         chk("vector_take", 16'(g), 16'(vt_n));
         rdc("wake_ctrl", REG_CTRL,
            (g == 1) ? 16'h003f : 16'h0037);
      end
      v = 16'($urandom);
      prep(v);
      wr(REG_CTRL, 16'h0080);
      @(posedge CLK_SYS);
      CAPTURE_PIN <= 1'h1;
      repeat (6) @(posedge CLK_SYS);
      CAPTURE_PIN <= 1'h0;
      rdc("cap_lo", REG_CAPCOMP_LO, {8'h00, v[7:0]});
      rdc("cap_hi", REG_CAPCOMP_HI, {8'h00, v[15:8]});
      for (int m = 2; m < 4; m++) begin
         prep(16'h0000);
         wr(REG_CAPCOMP_LO, 16'h0010);
         wr(REG_CAPCOMP_HI, 16'h0000);
         wr(REG_CTRL, 16'(m << 7) | 16'h000f);
         repeat (40) @(posedge CLK_SYS);
         rdc("cmp_flag", REG_FLAG, 16'h0002);
         chk("cmp_irq", 16'h0001, {15'h0000, COMPARE_IRQ});
         // Reloading 0f lands each write after the first on the match edge at 10h
         repeat (4) wr(REG_COUNT_LO, 16'h000f);
         rdc("period", REG_COUNT_HI, 16'h0000);
         // Last reload won at 10h; special mode then clears, compare counts
         rdc("period_lo", REG_COUNT_LO,
            (m == 3) ? 16'h0000 : 16'h0011);
      end
      wrap_up();
   end
endmodule : tb_timer_overflow_and_ccp_timebase
`default_nettype wire
